// file: logic/pll_test_override_regs.sv
// Purpose: APB register bank overriding synthesiser calibration for test
// Assumes: single clock core_clk at 10 MHz, calibrated inputs synchronous to it
// Notes:   slave answers with no wait states
//
// Functional notes
// - Probe-one select set routes test point 1 to the pump output pin, clear ties it to ground.
// - Probe-two select set routes test point 2 to the pump output pin, clear ties it to ground.
// - Pump-current force set applies the forced current value, otherwise the calibrated current.
// - The forced pump-current field is five bits and resets to 10000.
// - Pulse inhibit set suppresses up and down pump pulses, clear lets the pump run.
// - Oscillator-array force set applies the four-bit forced array value (reset 1000).
// - A six-bit bandwidth factor resetting to 100101 sets the loop bandwidth.
// - Loop break set opens the loop and applies the four-bit open-loop value (reset 0100).
// - A read-only five-bit field reports the pump current actually applied.
// - A read-only four-bit field reports the calibration value actually applied.
// - A read-only four-bit field reports the oscillator-array value actually applied.
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ns
module pll_test_override_regs (
  input  wire logic                     core_clk,
  input  wire logic                     reset_n,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [31:0]              paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output      logic [31:0]              prdata,
  output      logic                     pready,
  output      logic                     pslverr,
  input  wire ptor_pkg::ptor_synth_type calibrated,
  output      ptor_pkg::ptor_ctrl_type  synthCtrl
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] pumpCtrl;
  logic [7:0] oscCtrl;
  logic [7:0] bwFactor;
  logic [7:0] openLoop;
  logic       setupPhase;
  logic       mapped;
  logic       writeLow;
  logic [7:0] next_readByte;

  function automatic logic isMapped(input logic [31:0] addr);
    logic [4:0] off;
    off = addr[4:0];
    isMapped = (addr[31:5] == '0) &&
               (off == ptor_pkg::OFF_PUMP_CTRL || off == ptor_pkg::OFF_OSC_CTRL ||
                off == ptor_pkg::OFF_BW_FACTOR || off == ptor_pkg::OFF_OPEN_LOOP ||
                off == ptor_pkg::OFF_APPLIED_PUMP || off == ptor_pkg::OFF_APPLIED_CAL ||
                off == ptor_pkg::OFF_APPLIED_OSC);
  endfunction : isMapped

  // decode in the setup cycle so the answer is ready when the access phase opens
  assign setupPhase = psel && !penable;
  assign mapped     = isMapped(paddr);
  // only the low byte lane carries register bits
  assign writeLow   = setupPhase && pwrite && mapped && pstrb[0];

  ////////////////////////////////////////////////////////////////////////////
  // control registers; writes land at the setup edge, master holds them through access
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pumpCtrl <= ptor_pkg::RST_PUMP_CTRL;
      oscCtrl  <= ptor_pkg::RST_OSC_CTRL;
      bwFactor <= ptor_pkg::RST_BW_FACTOR;
      openLoop <= ptor_pkg::RST_OPEN_LOOP;
    end else if (writeLow) begin
      case (paddr[4:0])
        ptor_pkg::OFF_PUMP_CTRL: begin
          pumpCtrl <= pwdata[7:0] & ptor_pkg::MASK_PUMP_CTRL;
        end
        ptor_pkg::OFF_OSC_CTRL: begin
          oscCtrl <= pwdata[7:0] & ptor_pkg::MASK_OSC_CTRL;
        end
        ptor_pkg::OFF_BW_FACTOR: begin
          bwFactor <= pwdata[7:0] & ptor_pkg::MASK_BW_FACTOR;
        end
        ptor_pkg::OFF_OPEN_LOOP: begin
          openLoop <= pwdata[7:0] & ptor_pkg::MASK_OPEN_LOOP;
        end
        default: begin
          pumpCtrl <= pumpCtrl;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  ptor_apply_mux u_apply (
    .core_clk   (core_clk),
    .reset_n    (reset_n),
    .pumpCtrl   (pumpCtrl),
    .oscCtrl    (oscCtrl),
    .bwFactor   (bwFactor),
    .openLoop   (openLoop),
    .calibrated (calibrated),
    .applied    (synthCtrl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // status reads show the value driven to the synthesiser at that moment
  always_comb begin
    case (paddr[4:0])
      ptor_pkg::OFF_PUMP_CTRL:    next_readByte = pumpCtrl;
      ptor_pkg::OFF_OSC_CTRL:     next_readByte = oscCtrl;
      ptor_pkg::OFF_BW_FACTOR:    next_readByte = bwFactor;
      ptor_pkg::OFF_OPEN_LOOP:    next_readByte = openLoop;
      ptor_pkg::OFF_APPLIED_PUMP: next_readByte = {3'h0, synthCtrl.pumpCurrent};
      ptor_pkg::OFF_APPLIED_CAL:  next_readByte = {4'h0, synthCtrl.calValue};
      ptor_pkg::OFF_APPLIED_OSC:  next_readByte = {4'h0, synthCtrl.oscArray};
      default:                    next_readByte = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (setupPhase && !pwrite && mapped) begin
      prdata <= {24'h00_0000, next_readByte};
    end else if (setupPhase) begin
      prdata <= 32'h0000_0000;
    end
  end

  // one access-phase cycle: pready rises for the single access cycle only
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setupPhase;
      pslverr <= setupPhase && !mapped;
    end
  end

endmodule : pll_test_override_regs

// file: logic/ptor_pkg.sv
// Purpose: shared constants and types for the synthesiser test override register bank
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses
package ptor_pkg;

  localparam int          ADDR_W            = 5;
  localparam logic [4:0]  OFF_PUMP_CTRL     = 5'h18;
  localparam logic [4:0]  OFF_OSC_CTRL      = 5'h14;
  localparam logic [4:0]  OFF_BW_FACTOR     = 5'h10;
  localparam logic [4:0]  OFF_OPEN_LOOP     = 5'h0C;
  localparam logic [4:0]  OFF_APPLIED_PUMP  = 5'h08;
  localparam logic [4:0]  OFF_APPLIED_CAL   = 5'h04;
  localparam logic [4:0]  OFF_APPLIED_OSC   = 5'h00;

  localparam int          POS_PROBE_ONE     = 7;
  localparam int          POS_PROBE_TWO     = 6;
  localparam int          POS_PUMP_FORCE    = 5;
  localparam int          POS_PULSE_INHIBIT = 5;
  localparam int          POS_OSC_FORCE     = 4;
  localparam int          POS_BREAK_LOOP    = 4;

  localparam logic [7:0]  MASK_PUMP_CTRL    = 8'hFF;
  localparam logic [7:0]  MASK_OSC_CTRL     = 8'h3F;
  localparam logic [7:0]  MASK_BW_FACTOR    = 8'h3F;
  localparam logic [7:0]  MASK_OPEN_LOOP    = 8'h1F;

  localparam logic [7:0]  RST_PUMP_CTRL     = 8'h10;
  localparam logic [7:0]  RST_OSC_CTRL      = 8'h08;
  localparam logic [7:0]  RST_BW_FACTOR     = 8'h25;
  localparam logic [7:0]  RST_OPEN_LOOP     = 8'h04;

  // values the analogue side reports or calibrates
  typedef struct packed {
    logic [4:0] pumpCurrent;
    logic [3:0] calValue;
    logic [3:0] oscArray;
  } ptor_synth_type;

  // settings handed to the analogue side
  typedef struct packed {
    logic       probeOneSel;
    logic       probeTwoSel;
    logic       pulseInhibit;
    logic       loopOpen;
    logic [5:0] bandwidthFactor;
    logic [4:0] pumpCurrent;
    logic [3:0] oscArray;
    logic [3:0] calValue;
  } ptor_ctrl_type;

endpackage : ptor_pkg

// file: logic/ptor_apply_mux.sv
// Purpose: chooses between calibrated and forced synthesiser values
// Assumes: all inputs on core_clk
// Notes:   outputs registered so the top drives from flip-flops
`timescale 1ns/1ns
module ptor_apply_mux (
  input  wire logic                    core_clk,
  input  wire logic                    reset_n,
  input  wire logic [7:0]              pumpCtrl,
  input  wire logic [7:0]              oscCtrl,
  input  wire logic [7:0]              bwFactor,
  input  wire logic [7:0]              openLoop,
  input  wire ptor_pkg::ptor_synth_type calibrated,
  output      ptor_pkg::ptor_ctrl_type  applied
);

  ptor_pkg::ptor_ctrl_type next_applied;

  always_comb begin
    next_applied.probeOneSel     = pumpCtrl[ptor_pkg::POS_PROBE_ONE];
    next_applied.probeTwoSel     = pumpCtrl[ptor_pkg::POS_PROBE_TWO];
    next_applied.pulseInhibit    = oscCtrl[ptor_pkg::POS_PULSE_INHIBIT];
    next_applied.loopOpen        = openLoop[ptor_pkg::POS_BREAK_LOOP];
    next_applied.bandwidthFactor = bwFactor[5:0];
    next_applied.pumpCurrent     = pumpCtrl[ptor_pkg::POS_PUMP_FORCE] ? pumpCtrl[4:0]
                                                                       : calibrated.pumpCurrent;
    next_applied.oscArray        = oscCtrl[ptor_pkg::POS_OSC_FORCE] ? oscCtrl[3:0]
                                                                     : calibrated.oscArray;
    // the open-loop converter value only takes over while the loop is broken
    next_applied.calValue        = openLoop[ptor_pkg::POS_BREAK_LOOP] ? openLoop[3:0]
                                                                       : calibrated.calValue;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      applied <= '0;
    end else begin
      applied <= next_applied;
    end
  end

endmodule : ptor_apply_mux

// file: verification/ptor_checker.sv
// Purpose: port assertions for the test override register bank
// Assumes: zero wait state APB, synthCtrl registered one edge after a write
// Notes:   properties count from the setup edge
`timescale 1ns/1ns
module ptor_checker (
  input wire logic                     core_clk,
  input wire logic                     reset_n,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [31:0]              paddr,
  input wire logic [31:0]              pwdata,
  input wire logic [3:0]               pstrb,
  input wire logic [31:0]              prdata,
  input wire logic                     pready,
  input wire logic                     pslverr,
  input wire ptor_pkg::ptor_synth_type calibrated,
  input wire ptor_pkg::ptor_ctrl_type  synthCtrl
);
  wire       wr = psel & ~penable & pwrite & pstrb[0];
  wire       rd = psel & ~penable & ~pwrite;
  wire [4:0] st = paddr == 32'h8 ? synthCtrl.pumpCurrent : {1'b0, paddr == 32'h4 ? synthCtrl.calValue : synthCtrl.oscArray};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////
  property p_ans; psel && !penable |=> pready ##1 !pready; endproperty
  a_ans: assert property (p_ans) else $error("answer not in access cycle");
  property p_hi; pready |-> prdata[31:8] == 24'h0 && (!pslverr || prdata == 32'h0); endproperty
  a_hi: assert property (p_hi) else $error("unused read bits set");
  property p_pump; wr && paddr == 32'h18 |-> ##2 {synthCtrl.probeOneSel, synthCtrl.probeTwoSel} == $past(pwdata[7:6], 2)
    && (!$past(pwdata[5], 2) || synthCtrl.pumpCurrent == $past(pwdata[4:0], 2)); endproperty
  a_pump: assert property (p_pump) else $error("pump control not applied");
  property p_osc; wr && paddr == 32'h14 |-> ##2 synthCtrl.pulseInhibit == $past(pwdata[5], 2)
    && (!$past(pwdata[4], 2) || synthCtrl.oscArray == $past(pwdata[3:0], 2)); endproperty
  a_osc: assert property (p_osc) else $error("osc control not applied");
  property p_bw; wr && paddr == 32'h10 |-> ##2 synthCtrl.bandwidthFactor == $past(pwdata[5:0], 2); endproperty
  a_bw: assert property (p_bw) else $error("bandwidth not applied");
  property p_loop; wr && paddr == 32'h0C |-> ##2 synthCtrl.loopOpen == $past(pwdata[4], 2)
    && (!synthCtrl.loopOpen || synthCtrl.calValue == $past(pwdata[3:0], 2)); endproperty
  a_loop: assert property (p_loop) else $error("loop break not applied");
  property p_cal; $past(reset_n) && !synthCtrl.loopOpen |-> synthCtrl.calValue == $past(calibrated.calValue); endproperty
  a_cal: assert property (p_cal) else $error("closed loop cal wrong");
  property p_st; rd && paddr inside {32'h0, 32'h4, 32'h8} |=> prdata == {27'h0, $past(st)}; endproperty
  a_st: assert property (p_st) else $error("status read wrong");
  c_err: cover property (pready && pslverr);
  c_open: cover property (synthCtrl.loopOpen && synthCtrl.pulseInhibit);
  c_probe: cover property (synthCtrl.probeOneSel && synthCtrl.probeTwoSel);
endmodule : ptor_checker
bind pll_test_override_regs ptor_checker u_chk (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .calibrated(calibrated), .synthCtrl(synthCtrl));

// file: verification/ptor_synth_model.sv
// Purpose: analogue synthesiser stand-in reporting calibration results
// Assumes: a new calibration target settles after one core_clk
// Notes:   real calibration is far slower; shortened to keep runs brief
`timescale 1ns/1ns
module ptor_synth_model (
  input  wire logic                     core_clk,
  input  wire logic                     reset_n,
  input  wire ptor_pkg::ptor_synth_type target,
  output      ptor_pkg::ptor_synth_type calibrated
);
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) calibrated <= 13'h1FFF;
    else calibrated <= target;
  end
endmodule : ptor_synth_model

// file: verification/tb.sv
// Purpose: random and corner tests of the test override register bank
// Assumes: zero wait state APB slave, one idle cycle between transfers
// Notes:   expectations come from a shadow copy of the control registers
`timescale 1ns/1ns
module tb;
  logic                     core_clk = 1'b0;
  logic                     reset_n  = 1'b0;
  logic                     psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [31:0]              paddr = 32'h0, pwdata = 32'h0, prdata, rdata, r, seed = 32'h595FEACF;
  logic [3:0]               pstrb = 4'h0;
  logic [7:0]               rg [4];
  logic [7:0]               mk [4] = '{8'hFF, 8'h3F, 8'h3F, 8'h1F};
  ptor_pkg::ptor_synth_type target = 13'h0, calibrated;
  ptor_pkg::ptor_ctrl_type  synthCtrl;
  int                       fails = 0, checks = 0;
  pll_test_override_regs u_dut (.core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .calibrated(calibrated), .synthCtrl(synthCtrl));
  ptor_synth_model u_syn (.core_clk(core_clk), .reset_n(reset_n), .target(target), .calibrated(calibrated));
  initial forever #50 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [7:0] exp_rd(input logic [31:0] a);
    case (a)
      32'h18, 32'h14, 32'h10, 32'h0C: return rg[(32'h18 - a) >> 2];
      32'h08: return {3'h0, rg[0][5] ? rg[0][4:0] : target.pumpCurrent};
      32'h04: return {4'h0, rg[3][4] ? rg[3][3:0] : target.calValue};
      32'h00: return {4'h0, rg[1][4] ? rg[1][3:0] : target.oscArray};
      default: return 8'h0;
    endcase
  endfunction : exp_rd
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // one idle cycle between transfers keeps each strobe single-driven per step
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic read_all();
    for (int j = 0; j < 7; j++) begin
      apb(1'b0, 32'h18 - 4 * j, 32'h0, 4'h0);
      chk("read", rdata, exp_rd(32'h18 - 4 * j));
    end
  endtask : read_all
  task automatic give_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] a, d;
    rg = '{8'h10, 8'h08, 8'h25, 8'h04};
    r = rnd();
    target <= r[12:0];
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    read_all();
    chk("bandwidth", synthCtrl.bandwidthFactor, 6'h25);
    apb(1'b1, 32'h40, 32'hFFFFFFFF, 4'hF);
    chk("unmapped error", err, 1'b1);
    $display("test reset done");
    for (int k = 0; k < 60; k++) begin
      r = rnd();
      d = rnd();
      a = {27'h0, r[15:13], 2'h0};
      target <= r[12:0];
      apb(1'b1, a, d, r[16] ? 4'hF : 4'hE);
      chk("error", err, a == 32'h1C);
      if (r[16] && a >= 32'h0C && a <= 32'h18) rg[(32'h18 - a) >> 2] = d[7:0] & mk[(32'h18 - a) >> 2];
      read_all();
      chk("ctrl", {synthCtrl.probeOneSel, synthCtrl.probeTwoSel, synthCtrl.pulseInhibit},
        {rg[0][7:6], rg[1][5]});
      chk("loop", {synthCtrl.loopOpen, synthCtrl.bandwidthFactor}, {rg[3][4], rg[2][5:0]});
    end
    $display("test random done");
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    give_verdict();
  end
endmodule : tb
